// ---- src/macsaf_crc.sv ----
/*
  byte-wide ethernet crc over the destination address, least significant bit first.
  assumes bytes arrive on the same clock; init and data_valid never coincide.
*/
`timescale 1ns/1ps
module macsaf_crc
  import macsaf_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // byte stream
  input wire logic init,
  input wire logic data_valid,
  input wire logic [7:0] data,
  // running remainder
  output logic [31:0] crc_value
);

  logic [31:0] stage [0:8];

  assign stage[0] = crc_value;

  ////////////////////////////////////////////////////////////////////////////
  // one shift step per data bit
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic feedback;
      assign feedback = stage[i][0] ^ data[i];
      assign stage[i+1] = (stage[i] >> 1) ^ (feedback ? MACSAF_CRC_POLY : 32'h00000000);
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset || init) begin
      crc_value <= MACSAF_CRC_INIT;
    end else if (data_valid) begin
      crc_value <= stage[8];
    end
  end

endmodule : macsaf_crc

// ---- src/macsaf_pkg.sv ----
/*
  constants shared by the station address filter: register indices, field positions,
  reset values and timing figures.
  assumes a 100 MHz clock and a register port addressed by word index.
*/
package macsaf_pkg;

  // register indices on the register port
  localparam logic [7:0] MACSAF_CONTROL_IDX = 8'h01;
  localparam logic [7:0] MACSAF_ADDR_UPPER_IDX = 8'h02;
  localparam logic [7:0] MACSAF_ADDR_LOWER_IDX = 8'h03;
  localparam logic [7:0] MACSAF_HASH_UPPER_IDX = 8'h04;
  localparam logic [7:0] MACSAF_HASH_LOWER_IDX = 8'h05;
  localparam logic [7:0] MACSAF_IRQ_STATUS_IDX = 8'h10;
  localparam logic [7:0] MACSAF_IRQ_MASK_IDX = 8'h11;
  localparam logic [7:0] MACSAF_STATE_IDX = 8'h12;

  // control register fields
  localparam int MACSAF_RECEIVE_ON_BIT = 2;
  localparam int MACSAF_TRANSMIT_ON_BIT = 3;
  localparam int MACSAF_DEFER_CHECK_BIT = 5;
  localparam int MACSAF_GROUP_ALL_BIT = 6;
  localparam logic [31:0] MACSAF_CONTROL_MASK = 32'h0000006C;

  // interrupt status fields
  localparam int MACSAF_IRQ_LOAD_DONE = 0;
  localparam int MACSAF_IRQ_DEFER_ABORT = 1;
  localparam int MACSAF_IRQ_ACCEPT = 2;
  localparam int MACSAF_IRQ_REJECT = 3;
  localparam int MACSAF_IRQ_WIDTH = 4;

  // reset values and the upper address write mask
  localparam logic [31:0] MACSAF_CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] MACSAF_ADDR_UPPER_RESET = 32'h00000FFF;
  localparam logic [31:0] MACSAF_ADDR_LOWER_RESET = 32'h0FFFFFFF;
  localparam logic [31:0] MACSAF_HASH_RESET = 32'h00000000;
  localparam logic [31:0] MACSAF_ADDR_UPPER_FIELD = 32'h0000FFFF;

  // configuration memory locations of the station address
  localparam logic [7:0] MACSAF_CFG_FIRST_LOC = 8'h01;
  localparam logic [7:0] MACSAF_CFG_LAST_LOC = 8'h06;

  // timing
  localparam int MACSAF_CLOCK_PERIOD_NS = 10;
  localparam int MACSAF_BIT_TIME_10M_NS = 100;
  localparam int MACSAF_BIT_TIME_100M_NS = 10;
  localparam int MACSAF_BIT_CYCLES_10M = MACSAF_BIT_TIME_10M_NS / MACSAF_CLOCK_PERIOD_NS;
  localparam int MACSAF_BIT_CYCLES_100M = MACSAF_BIT_TIME_100M_NS / MACSAF_CLOCK_PERIOD_NS;
  localparam int MACSAF_DEFER_LIMIT_BITS = 24288;

  // ethernet crc, reflected form
  localparam logic [31:0] MACSAF_CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] MACSAF_CRC_INIT = 32'hFFFFFFFF;
  localparam int MACSAF_DEST_BYTES = 6;

  typedef enum logic [2:0] {
    MACSAF_LD_START,
    MACSAF_LD_REQUEST,
    MACSAF_LD_WAIT,
    MACSAF_LD_DONE
  } macsaf_load_e;

endpackage : macsaf_pkg

// ---- src/macsaf_top.sv ----
/*
  station address, multicast hash filter, path enables and deferral limit of a 10/100 mac.
  assumes the phy byte stream and the configuration memory reader share this clock;
  carrier sense arrives unsynchronised.
*/
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module macsaf_top
  import macsaf_pkg::*;
#(
  parameter int DEFER_LIMIT_BITS = MACSAF_DEFER_LIMIT_BITS
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  // configuration memory reader
  input wire logic cfg_present,
  output logic cfg_rd_req,
  output logic [7:0] cfg_rd_addr,
  input wire logic cfg_rd_valid,
  input wire logic [7:0] cfg_rd_data,
  output logic addr_load_done,
  // transmit side
  input wire logic link_speed_10,
  input wire logic carrier_sense,
  input wire logic tx_frame_ready,
  output logic tx_go,
  output logic tx_defer_abort,
  // receive side
  input wire logic rx_start,
  input wire logic rx_data_valid,
  input wire logic [7:0] rx_data,
  output logic rx_frame_accept,
  output logic rx_frame_reject
);

  localparam int DEFER_COUNT_WIDTH = $clog2(DEFER_LIMIT_BITS + 2);
  localparam logic [DEFER_COUNT_WIDTH-1:0] DEFER_LIMIT =
    DEFER_COUNT_WIDTH'(DEFER_LIMIT_BITS);

  logic [31:0] control_reg;
  logic [31:0] addr_upper_reg;
  logic [31:0] addr_lower_reg;
  logic [31:0] hash_upper_reg;
  logic [31:0] hash_lower_reg;
  logic [MACSAF_IRQ_WIDTH-1:0] irq_status_reg;
  logic [MACSAF_IRQ_WIDTH-1:0] irq_status_next;
  logic [MACSAF_IRQ_WIDTH-1:0] irq_mask_reg;
  logic [MACSAF_IRQ_WIDTH-1:0] irq_event;

  logic receive_path_on;
  logic transmit_path_on;
  logic deferral_limit_check;
  logic accept_every_group_frame;

  ////////////////////////////////////////////////////////////////////////////
  // control bits
  assign receive_path_on = control_reg[MACSAF_RECEIVE_ON_BIT];
  assign transmit_path_on = control_reg[MACSAF_TRANSMIT_ON_BIT];
  assign deferral_limit_check = control_reg[MACSAF_DEFER_CHECK_BIT];
  assign accept_every_group_frame = control_reg[MACSAF_GROUP_ALL_BIT];

  always_ff @(posedge clock) begin
    if (reset) begin
      control_reg <= MACSAF_CONTROL_RESET;
    end else if (reg_write && reg_addr == MACSAF_CONTROL_IDX) begin
      control_reg <= reg_wdata & MACSAF_CONTROL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // station address load from configuration memory
  macsaf_load_e load_state;
  logic load_byte;
  logic [7:0] load_loc;
  logic present_seen;

  always_ff @(posedge clock) begin
    if (reset) begin
      load_state <= MACSAF_LD_START;
      cfg_rd_req <= 1'b0;
      cfg_rd_addr <= MACSAF_CFG_FIRST_LOC;
      addr_load_done <= 1'b0;
      present_seen <= 1'b0;
    end else begin
      cfg_rd_req <= 1'b0;
      case (load_state)
        MACSAF_LD_START: begin
          // programmed memory is caught once, after reset release
          present_seen <= cfg_present;
          cfg_rd_addr <= MACSAF_CFG_FIRST_LOC;
          load_state <= cfg_present ? MACSAF_LD_REQUEST : MACSAF_LD_DONE;
        end
        MACSAF_LD_REQUEST: begin
          cfg_rd_req <= 1'b1;
          load_state <= MACSAF_LD_WAIT;
        end
        MACSAF_LD_WAIT: begin
          if (cfg_rd_valid) begin
            if (cfg_rd_addr == MACSAF_CFG_LAST_LOC) begin
              load_state <= MACSAF_LD_DONE;
            end else begin
              cfg_rd_addr <= cfg_rd_addr + 8'h01;
              load_state <= MACSAF_LD_REQUEST;
            end
          end
        end
        MACSAF_LD_DONE: begin
          addr_load_done <= 1'b1;
        end
        default: begin
          load_state <= MACSAF_LD_DONE;
        end
      endcase
    end
  end

  assign load_byte = (load_state == MACSAF_LD_WAIT) && cfg_rd_valid;
  assign load_loc = cfg_rd_addr - MACSAF_CFG_FIRST_LOC;

  ////////////////////////////////////////////////////////////////////////////
  // station address registers; a loaded byte wins over a host write
  always_ff @(posedge clock) begin
    if (reset) begin
      addr_lower_reg <= MACSAF_ADDR_LOWER_RESET;
    end else if (load_byte && load_loc < 8'h04) begin
      addr_lower_reg[load_loc[1:0]*8 +: 8] <= cfg_rd_data;
    end else if (reg_write && reg_addr == MACSAF_ADDR_LOWER_IDX) begin
      addr_lower_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      addr_upper_reg <= MACSAF_ADDR_UPPER_RESET;
    end else if (load_byte && load_loc >= 8'h04) begin
      addr_upper_reg[load_loc[0]*8 +: 8] <= cfg_rd_data;
    end else if (reg_write && reg_addr == MACSAF_ADDR_UPPER_IDX) begin
      addr_upper_reg <= reg_wdata & MACSAF_ADDR_UPPER_FIELD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multicast hash table
  always_ff @(posedge clock) begin
    if (reset) begin
      hash_upper_reg <= MACSAF_HASH_RESET;
    end else if (reg_write && reg_addr == MACSAF_HASH_UPPER_IDX) begin
      hash_upper_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      hash_lower_reg <= MACSAF_HASH_RESET;
    end else if (reg_write && reg_addr == MACSAF_HASH_LOWER_IDX) begin
      hash_lower_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carrier sense synchroniser; a change counts once stages two and three agree
  logic crs_meta;
  logic crs_sync2;
  logic crs_sync3;
  logic crs_level;

  always_ff @(posedge clock) begin
    if (reset) begin
      crs_meta <= 1'b0;
      crs_sync2 <= 1'b0;
      crs_sync3 <= 1'b0;
      crs_level <= 1'b0;
    end else begin
      crs_meta <= carrier_sense;
      crs_sync2 <= crs_meta;
      crs_sync3 <= crs_sync2;
      if (crs_sync2 == crs_sync3) begin
        crs_level <= crs_sync3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit time enable: every cycle at 100 Mb/s, every tenth at 10 Mb/s
  logic [3:0] bit_div;
  logic bit_tick;

  always_ff @(posedge clock) begin
    if (reset) begin
      bit_div <= 4'h0;
      bit_tick <= 1'b0;
    end else begin
      if (bit_div >= 4'((link_speed_10 ? MACSAF_BIT_CYCLES_10M : MACSAF_BIT_CYCLES_100M) - 1)) begin
        bit_div <= 4'h0;
        bit_tick <= 1'b1;
      end else begin
        bit_div <= bit_div + 4'h1;
        bit_tick <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // deferral timer and transmit gate
  logic deferring;
  logic abort_hold;
  logic [DEFER_COUNT_WIDTH-1:0] defer_count;

  assign deferring = tx_frame_ready && transmit_path_on && crs_level && !abort_hold;

  always_ff @(posedge clock) begin
    if (reset) begin
      defer_count <= '0;
    end else if (!deferring) begin
      defer_count <= '0;
    end else if (bit_tick && defer_count <= DEFER_LIMIT) begin
      defer_count <= defer_count + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      abort_hold <= 1'b0;
      tx_defer_abort <= 1'b0;
    end else begin
      tx_defer_abort <= 1'b0;
      if (!tx_frame_ready) begin
        abort_hold <= 1'b0;
      end else if (deferring && deferral_limit_check && defer_count > DEFER_LIMIT) begin
        // the attempt is dropped until the frame source withdraws it
        abort_hold <= 1'b1;
        tx_defer_abort <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_go <= 1'b0;
    end else begin
      tx_go <= tx_frame_ready && transmit_path_on && !crs_level && !abort_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // destination address capture and filter
  logic rx_active;
  logic [2:0] rx_count;
  logic [47:0] dest_addr;
  logic decide_pending;
  logic crc_feed;
  logic [31:0] crc_value;
  logic [5:0] hash_index;
  logic hash_bit;
  logic is_group;
  logic station_match;
  logic frame_ok;

  assign crc_feed = rx_active && rx_data_valid && rx_count < 3'(MACSAF_DEST_BYTES);

  macsaf_crc u_crc (
    .clock(clock),
    .reset(reset),
    .init(rx_start),
    .data_valid(crc_feed),
    .data(rx_data),
    .crc_value(crc_value)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_active <= 1'b0;
      rx_count <= 3'h0;
      dest_addr <= 48'h000000000000;
      decide_pending <= 1'b0;
    end else if (rx_start) begin
      rx_active <= receive_path_on;
      rx_count <= 3'h0;
      decide_pending <= 1'b0;
    end else if (crc_feed) begin
      dest_addr[rx_count*8 +: 8] <= rx_data;
      rx_count <= rx_count + 3'h1;
      decide_pending <= (rx_count == 3'(MACSAF_DEST_BYTES - 1));
    end else begin
      decide_pending <= 1'b0;
    end
  end

  // top six bits of the standard crc sit reversed in the low bits of the reflected remainder
  assign hash_index = {crc_value[0], crc_value[1], crc_value[2],
                       crc_value[3], crc_value[4], crc_value[5]};
  assign hash_bit = hash_index[5] ? hash_upper_reg[hash_index[4:0]]
                                  : hash_lower_reg[hash_index[4:0]];
  assign is_group = dest_addr[0];
  assign station_match = dest_addr == {addr_upper_reg[15:0], addr_lower_reg};
  assign frame_ok = is_group ? (accept_every_group_frame || hash_bit)
                             : station_match;

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_frame_accept <= 1'b0;
      rx_frame_reject <= 1'b0;
    end else begin
      rx_frame_accept <= decide_pending && frame_ok;
      rx_frame_reject <= decide_pending && !frame_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, a new event wins over the clear
  assign irq_event = {decide_pending && !frame_ok, decide_pending && frame_ok,
                      deferring && deferral_limit_check && defer_count > DEFER_LIMIT
                        && tx_frame_ready,
                      load_state == MACSAF_LD_DONE && !addr_load_done};

  always_comb begin
    irq_status_next = irq_status_reg;
    if (reg_write && reg_addr == MACSAF_IRQ_STATUS_IDX) begin
      irq_status_next = irq_status_next & ~reg_wdata[MACSAF_IRQ_WIDTH-1:0];
    end
    irq_status_next = irq_status_next | irq_event;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (reg_write && reg_addr == MACSAF_IRQ_MASK_IDX) begin
        irq_mask_reg <= reg_wdata[MACSAF_IRQ_WIDTH-1:0];
      end
      irq <= |(irq_status_next & (reg_write && reg_addr == MACSAF_IRQ_MASK_IDX
                                  ? reg_wdata[MACSAF_IRQ_WIDTH-1:0] : irq_mask_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      case (reg_addr)
        MACSAF_CONTROL_IDX: reg_rdata <= control_reg;
        MACSAF_ADDR_UPPER_IDX: reg_rdata <= addr_upper_reg;
        MACSAF_ADDR_LOWER_IDX: reg_rdata <= addr_lower_reg;
        MACSAF_HASH_UPPER_IDX: reg_rdata <= hash_upper_reg;
        MACSAF_HASH_LOWER_IDX: reg_rdata <= hash_lower_reg;
        MACSAF_IRQ_STATUS_IDX: reg_rdata <= {28'h0000000, irq_status_reg};
        MACSAF_IRQ_MASK_IDX: reg_rdata <= {28'h0000000, irq_mask_reg};
        MACSAF_STATE_IDX: reg_rdata <= {27'h0000000, present_seen, rx_active,
                                        abort_hold, deferring, addr_load_done};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : macsaf_top

// ---- verification/macsaf_cfg_mem.sv ----
/* configuration memory model answering the address loader.
   assumes requests are single-cycle pulses; location n holds 0xA0 + n. */
`timescale 1ns/1ps
module macsaf_cfg_mem #(
  parameter int LATENCY = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // reader port
  input wire logic cfg_rd_req,
  input wire logic [7:0] cfg_rd_addr,
  output logic cfg_rd_valid,
  output logic [7:0] cfg_rd_data
);
  logic [7:0] loc_reg;
  int wait_reg;
  always_ff @(posedge clock) begin
    cfg_rd_valid <= 1'b0;
    if (reset) begin
      wait_reg <= 0;
      cfg_rd_data <= 8'h00;
    end else if (cfg_rd_req) begin
      loc_reg <= cfg_rd_addr;
      wait_reg <= LATENCY;
      cfg_rd_data <= ~cfg_rd_data;
    end else if (wait_reg == 1) begin
      wait_reg <= 0;
      cfg_rd_valid <= 1'b1;
      cfg_rd_data <= {4'hA, loc_reg[3:0]};
    end else begin
      // data line toggles while no answer stands
      if (wait_reg > 1) wait_reg <= wait_reg - 1;
      cfg_rd_data <= ~cfg_rd_data;
    end
  end
endmodule : macsaf_cfg_mem

// ---- verification/macsaf_properties.sv ----
/* port checker for the station address filter top.
   assumes one clock domain and binding from the bench top file. */
`timescale 1ns/1ps
module macsaf_properties
  import macsaf_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // watched ports
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic cfg_rd_req,
  input wire logic [7:0] cfg_rd_addr,
  input wire logic addr_load_done,
  input wire logic tx_frame_ready,
  input wire logic tx_go,
  input wire logic tx_defer_abort,
  input wire logic rx_frame_accept,
  input wire logic rx_frame_reject
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_go_needs_ready: assert property (tx_go |-> $past(tx_frame_ready))
    else $error("tx_go without a waiting frame");
  a_abort_one_cycle: assert property (tx_defer_abort |=> !tx_defer_abort)
    else $error("abort pulse longer than one cycle");
  a_abort_while_held: assert property (tx_defer_abort |-> !tx_go && $past(tx_frame_ready))
    else $error("abort outside a deferral");
  a_verdict_single: assert property (!(rx_frame_accept && rx_frame_reject))
    else $error("accept and reject together");
  a_accept_one_cycle: assert property (rx_frame_accept |=> !rx_frame_accept)
    else $error("accept pulse longer than one cycle");
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 32'h00000000)
    else $error("read data outside read answer");
  a_cfg_req_pulse: assert property (cfg_rd_req |=> !cfg_rd_req)
    else $error("config request longer than one cycle");
  a_cfg_addr_range: assert property (cfg_rd_req |->
    cfg_rd_addr >= MACSAF_CFG_FIRST_LOC && cfg_rd_addr <= MACSAF_CFG_LAST_LOC)
    else $error("config location out of range");
  a_done_sticky: assert property (addr_load_done |=> addr_load_done)
    else $error("load done dropped");
  c_accept: cover property (rx_frame_accept);
  c_reject: cover property (rx_frame_reject);
  c_abort: cover property (tx_defer_abort);
  c_loaded: cover property ($rose(addr_load_done));
endmodule : macsaf_properties

// ---- verification/macsaf_tb_top.sv ----
/* self-checking bench for the station address filter.
   assumes a config memory model on the loader port and a 100 MHz clock. */
`timescale 1ns/1ps
module macsaf_tb_top
  import macsaf_pkg::*;
  ;
  localparam int LIMIT = 20;
  localparam logic [47:0] GRP = 48'h3412005E0001;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} macsaf_row_s;
  macsaf_row_s rows [7] = '{
    '{MACSAF_CONTROL_IDX, 32'hFFFFFFFF, 32'h0000006C},
    '{MACSAF_ADDR_UPPER_IDX, 32'hFFFFFFFF, 32'h0000FFFF},
    '{MACSAF_ADDR_LOWER_IDX, 32'h12345678, 32'h12345678},
    '{MACSAF_HASH_UPPER_IDX, 32'hA5A5A5A5, 32'hA5A5A5A5},
    '{MACSAF_HASH_LOWER_IDX, 32'h5A5A5A5A, 32'h5A5A5A5A},
    '{MACSAF_IRQ_MASK_IDX, 32'hFFFFFFFF, 32'h0000000F},
    '{8'h0F, 32'hFFFFFFFF, 32'h00000000}};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] rx_data = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic cfg_present = 1'b1;
  logic carrier_sense = 1'b0;
  logic tx_frame_ready = 1'b0;
  logic rx_start = 1'b0;
  logic rx_data_valid = 1'b0;
  logic link_speed_10 = 1'b0;
  logic irq, cfg_rd_req, cfg_rd_valid, addr_load_done, tx_go, tx_defer_abort;
  logic rx_frame_accept, rx_frame_reject;
  logic [7:0] cfg_rd_addr, cfg_rd_data;
  logic [5:0] hi;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_acc = 0;
  int n_rej = 0;
  int n_ab = 0;
  macsaf_top #(.DEFER_LIMIT_BITS(LIMIT)) i_macsaf_top (.clock, .reset, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq, .cfg_present, .cfg_rd_req,
    .cfg_rd_addr, .cfg_rd_valid, .cfg_rd_data, .addr_load_done, .link_speed_10,
    .carrier_sense, .tx_frame_ready, .tx_go, .tx_defer_abort, .rx_start, .rx_data_valid,
    .rx_data, .rx_frame_accept, .rx_frame_reject);
  macsaf_cfg_mem #(.LATENCY(3)) i_macsaf_cfg_mem (.clock, .reset, .cfg_rd_req,
    .cfg_rd_addr, .cfg_rd_valid, .cfg_rd_data);
  ////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : rdc
  task automatic frame(input logic [47:0] d, input int ea, input int er);
    int a0, r0;
    a0 = n_acc;
    r0 = n_rej;
    @(posedge clock);
    rx_start <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      @(posedge clock);
      rx_start <= 1'b0;
      rx_data_valid <= 1'b1;
      rx_data <= d[8*k +: 8];
    end
    @(posedge clock);
    rx_data_valid <= 1'b0;
    repeat (4) @(posedge clock);
    #1 check(n_acc - a0, ea);
    check(n_rej - r0, er);
  endtask : frame
  task automatic wait_done();
    for (int i = 0; i < 100 && addr_load_done !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check(addr_load_done, 1'b1);
  endtask : wait_done
  task automatic drive_tx(input logic rdy, input logic crs, input int n);
    @(posedge clock);
    tx_frame_ready <= rdy;
    carrier_sense <= crs;
    repeat (n) @(posedge clock);
    #1;
  endtask : drive_tx
  // reflected crc, destination byte 0 bit 0 first
  function automatic logic [5:0] hidx(input logic [47:0] d);
    logic [31:0] c;
    c = MACSAF_CRC_INIT;
    for (int i = 0; i < 48; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? MACSAF_CRC_POLY : 32'h0);
    return {c[0], c[1], c[2], c[3], c[4], c[5]};
  endfunction : hidx
  ////////////////////////////////////////
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    n_acc <= n_acc + int'(rx_frame_accept === 1'b1);
    n_rej <= n_rej + int'(rx_frame_reject === 1'b1);
    n_ab <= n_ab + int'(tx_defer_abort === 1'b1);
    if (cycles == 5000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    wait_done();
    rdc(MACSAF_ADDR_LOWER_IDX, 32'hA4A3A2A1);
    rdc(MACSAF_ADDR_UPPER_IDX, 32'h0000A6A5);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e);
    end
    wr(MACSAF_IRQ_STATUS_IDX, 32'h0000000F);
    wr(MACSAF_IRQ_MASK_IDX, 32'h00000004);
    wr(MACSAF_HASH_UPPER_IDX, 32'h00000000);
    wr(MACSAF_HASH_LOWER_IDX, 32'h00000000);
    frame(48'hFFFF12345678, 1, 0);
    check(irq, 1'b1);
    wr(MACSAF_IRQ_STATUS_IDX, 32'h00000004);
    repeat (2) @(posedge clock);
    #1 check(irq, 1'b0);
    frame(48'hFFFF12345778, 0, 1);
    check(irq, 1'b0);
    frame(GRP, 1, 0);
    wr(MACSAF_CONTROL_IDX, 32'h0000002C);
    frame(GRP, 0, 1);
    hi = hidx(GRP);
    wr(hi[5] ? MACSAF_HASH_UPPER_IDX : MACSAF_HASH_LOWER_IDX, 32'h1 << hi[4:0]);
    frame(GRP, 1, 0);
    wr(MACSAF_CONTROL_IDX, 32'h00000068);
    frame(GRP, 0, 0);
    wr(MACSAF_CONTROL_IDX, 32'h00000028);
    drive_tx(1'b1, 1'b1, LIMIT);
    check(n_ab, 0);
    drive_tx(1'b1, 1'b1, 20);
    check(n_ab, 1);
    check(tx_go, 1'b0);
    rdc(MACSAF_IRQ_STATUS_IDX, 32'h0000000E);
    rdc(MACSAF_STATE_IDX, 32'h00000015);
    drive_tx(1'b0, 1'b0, 2);
    drive_tx(1'b1, 1'b1, LIMIT - 5);
    drive_tx(1'b1, 1'b0, 6);
    check(tx_go, 1'b1);
    drive_tx(1'b0, 1'b1, 2);
    drive_tx(1'b1, 1'b1, LIMIT - 5);
    check(n_ab, 1);
    wr(MACSAF_CONTROL_IDX, 32'h00000008);
    drive_tx(1'b1, 1'b1, 3 * LIMIT);
    check(n_ab, 1);
    wr(MACSAF_CONTROL_IDX, 32'h00000000);
    drive_tx(1'b1, 1'b0, 8);
    check(tx_go, 1'b0);
    drive_tx(1'b0, 1'b0, 1);
    // 10 Mb/s: ten clock cycles per bit time stretch the deferral limit tenfold
    @(posedge clock);
    link_speed_10 <= 1'b1;
    wr(MACSAF_CONTROL_IDX, 32'h00000028);
    drive_tx(1'b1, 1'b1, 10 * LIMIT);
    check(n_ab, 1);
    drive_tx(1'b1, 1'b1, 5 * LIMIT);
    check(n_ab, 2);
    drive_tx(1'b0, 1'b0, 2);
    @(posedge clock);
    reset <= 1'b1;
    cfg_present <= 1'b0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    wait_done();
    rdc(MACSAF_ADDR_UPPER_IDX, MACSAF_ADDR_UPPER_RESET);
    rdc(MACSAF_ADDR_LOWER_IDX, MACSAF_ADDR_LOWER_RESET);
    rdc(MACSAF_HASH_UPPER_IDX, MACSAF_HASH_RESET);
    rdc(MACSAF_CONTROL_IDX, MACSAF_CONTROL_RESET);
    complete_run();
  end
endmodule : macsaf_tb_top

bind macsaf_top macsaf_properties i_macsaf_properties (.clock, .reset, .reg_read,
  .reg_rdata, .cfg_rd_req, .cfg_rd_addr, .addr_load_done, .tx_frame_ready, .tx_go,
  .tx_defer_abort, .rx_frame_accept, .rx_frame_reject);
